// ===== sws_defs.svh
// Constants for the switch fault supervisor: counts, timing and the full duty value.
// Assumes inclusion by the package and the supervisor; definitions only.
`ifndef SWS_DEFS_SVH
`define SWS_DEFS_SVH

`define SWS_NCH            4
`define SWS_RETRY_MAX      5'h10
`define SWS_AUTO_PERIOD_US 32'd150000
`define SWS_LED_OPEN_LOAD_SELECT_US       32'd15000
`define SWS_CLK_MHZ        32'd10
`define SWS_DUTY_FULL      7'h7f

`endif

// ===== sws_pkg.sv
// Types for the switch fault supervisor.
// Assumes sws_defs.svh supplies the numeric constants.
`include "sws_defs.svh"
package sws_pkg;
    // Per-channel analog comparator results, already synchronous
    typedef struct packed {
        logic [3:0] overcurrent;
        logic [3:0] overtemp;
        logic [3:0] short_sense;
        logic [3:0] off_open_sense;
        logic [3:0] on_low_current;
    } chan_sense_s;

    // Software configuration bits
    typedef struct packed {
        logic       overvoltage_protect_disable;
        logic       retry_disable;
        logic [3:0] short_to_supply_disable;
        logic [3:0] off_open_load_disable;
        logic [3:0] on_open_load_disable;
        logic [3:0] led_open_load_select;
        logic [1:0] sense_route;
    } config_s;

    // Sticky fault report
    typedef struct packed {
        logic       overvoltage_flag;
        logic       undervoltage_flag;
        logic       temp_prewarn_flag;
        logic [3:0] overtemp_flag;
        logic [3:0] overcurrent_flag;
        logic [3:0] short_to_supply_flag;
        logic [3:0] off_open_load_flag;
        logic [3:0] on_open_load_flag;
    } status_s;

    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_EXHAUSTED} retry_state_e;
endpackage

// ===== switch_fault_supervisor.sv
// Fault supervision for a four-channel high-side switch.
// Assumes comparator and command inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`include "sws_defs.svh"

// Behaviour
// RULE1 - Over-voltage shuts all outputs, fault pin low
// RULE2 - Stay off until hysteresis; flag clears on read
// RULE3 - Protect disabled: warn only, clear when gone
// RULE4 - Fail-safe: over-voltage shutdown follows wake input
// RULE5 - Under-voltage: outputs off, pin low, flag set
// RULE6 - Recovery, outputs off: pin high, flag kept
// RULE7 - Recovery, output on: latched until delatch event
// RULE8 - Under-voltage keeps configuration with logic supply
// RULE9 - Supply failures clear all latched faults; code keeps short, open-load and prewarn flags
// RULE10 - Retry request is overcurrent, overtemp or undervoltage
// RULE11 - Retry after one period, sixteen attempts max
// RULE12 - Retry counter reset on mode change, disable toggle
// RULE13 - Each retry restores inrush current profile
// RULE14 - Off-state short latches short and open flags
// RULE15 - Per-output short detection disable
// RULE16 - Off-state open-load latches, clears when gone
// RULE17 - Per-output off-state open-load disable
// RULE18 - On-state open-load flags only, output unaffected
// RULE19 - LED mode: periodic check at full duty
// RULE20 - On open-load clears on read when gone
// RULE21 - Sense current only when on, not fail-safe
// RULE22 - Normal mode prewarning latches, clears on read
// RULE23 - Flags presented and cleared on valid transfer
// RULE24 - Exhausted retries latch off until toggle
module switch_fault_supervisor #(
    parameter int unsigned AUTO_PERIOD_CYC = `SWS_AUTO_PERIOD_US * `SWS_CLK_MHZ,
    parameter int unsigned LED_OPEN_LOAD_SELECT_CYC       = `SWS_LED_OPEN_LOAD_SELECT_US * `SWS_CLK_MHZ
) (
    // Clock and control
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    // Supply and mode status
    input  wire logic                 overvoltage_sense,
    input  wire logic                 overvoltage_clear_sense,
    input  wire logic                 undervoltage_sense,
    input  wire logic                 logic_supply_fail,
    input  wire logic                 supply_por,
    input  wire logic                 fail_safe_mode,
    input  wire logic                 wake_reset_in,
    input  wire logic                 fault_mode,
    input  wire logic                 prewarn_sense,
    // Channel command and sensing
    input  wire logic [3:0]           output_command,
    input  wire logic [3:0][6:0]      duty,
    input  wire sws_pkg::chan_sense_s sense,
    input  wire sws_pkg::config_s     cfg,
    // Status read strobe
    input  wire logic                 status_read,
    // Results
    output logic [3:0]                switch_output,
    output logic [3:0]                inrush_restore,
    output logic [3:0]                sense_output,
    output logic                      fault_flag_pin,
    output sws_pkg::status_s          status
);
    import sws_pkg::*;

    localparam int unsigned N = `SWS_NCH;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        status_s            st;
        logic [3:0]         latched_off;
        logic [3:0]         cmd_prev;
        logic               ov_off;
        logic               fs_prev;
        logic               rd_prev;
        logic [3:0]         on_out;
        logic [3:0]         inrush;
        logic [3:0][4:0]    retries;
        retry_state_e [3:0] rstate;
        logic [3:0][31:0]   timer;
        logic [3:0][31:0]   on_time;
    } state_s;

    state_s cur;
    state_s next_cur;

    logic ov_active;
    logic latch_clear;
    logic retry_reset;

    assign ov_active   = !cfg.overvoltage_protect_disable
                         && (!fail_safe_mode || wake_reset_in);         // [RULE1] [RULE3] [RULE4]
    assign latch_clear = logic_supply_fail || supply_por;               // [RULE9]
    assign retry_reset = (fail_safe_mode != cur.fs_prev)
                         || (cfg.retry_disable != cur.rd_prev);         // [RULE12]

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic [3:0] req;
        logic [3:0] off_now;
        req      = '0;
        off_now  = '0;
        next_cur = cur;
        next_cur.fs_prev  = fail_safe_mode;
        next_cur.rd_prev  = cfg.retry_disable;
        next_cur.cmd_prev = output_command;
        next_cur.inrush   = '0;

        // Read clears flags whose condition is gone; a live event re-sets them
        if (status_read) begin                                          // [RULE23]
            next_cur.st.overvoltage_flag  = 1'b0;                       // [RULE2]
            next_cur.st.undervoltage_flag = 1'b0;                       // [RULE6]
            next_cur.st.temp_prewarn_flag = 1'b0;                       // [RULE22]
            next_cur.st.overtemp_flag     = '0;
            next_cur.st.overcurrent_flag  = '0;
            next_cur.st.short_to_supply_flag = '0;
            next_cur.st.off_open_load_flag   = '0;
            next_cur.st.on_open_load_flag    = '0;                      // [RULE20]
        end

        // Over-voltage: set always, shutdown only when protection active
        if (overvoltage_sense) begin
            next_cur.st.overvoltage_flag = 1'b1;                        // [RULE3]
            if (ov_active)
                next_cur.ov_off = 1'b1;                                 // [RULE1]
        end else if (overvoltage_clear_sense || !ov_active) begin
            next_cur.ov_off = 1'b0;                                     // [RULE2]
        end

        // Under-voltage latches; configuration is never touched here
        if (undervoltage_sense)
            next_cur.st.undervoltage_flag = 1'b1;                       // [RULE5] [RULE8]
        if (fail_safe_mode == 1'b0 && prewarn_sense)
            next_cur.st.temp_prewarn_flag = 1'b1;                       // [RULE22]

        for (int i = 0; i < N; i++) begin
            // Latch-off for faults of a commanded-on output
            if (output_command[i] && (sense.overcurrent[i] || sense.overtemp[i]
                                      || undervoltage_sense))
                next_cur.latched_off[i] = 1'b1;                         // [RULE5] [RULE7]
            if (sense.overcurrent[i])
                next_cur.st.overcurrent_flag[i] = 1'b1;
            if (sense.overtemp[i])
                next_cur.st.overtemp_flag[i] = 1'b1;

            // Toggle off then on delatches once the cause is gone
            if (output_command[i] && !cur.cmd_prev[i] && !sense.overcurrent[i]
                && !sense.overtemp[i] && !undervoltage_sense) begin
                next_cur.latched_off[i] = 1'b0;                         // [RULE7] [RULE24]
                next_cur.retries[i]     = '0;
                next_cur.rstate[i]      = RS_IDLE;
            end

            // Autoretry
            req[i] = cur.st.overcurrent_flag[i] || cur.st.overtemp_flag[i]
                     || cur.st.undervoltage_flag;                       // [RULE10]
            case (cur.rstate[i])
                RS_IDLE: begin
                    if (fault_mode && !cfg.retry_disable && req[i] && cur.latched_off[i]) begin
                        next_cur.rstate[i] = RS_WAIT;
                        next_cur.timer[i]  = '0;
                    end
                end
                RS_WAIT: begin
                    if (!fault_mode || cfg.retry_disable) begin
                        next_cur.rstate[i] = RS_IDLE;
                    end else if (cur.timer[i] >= AUTO_PERIOD_CYC - 1) begin  // [RULE11]
                        // Over-current is only seen while conducting, so an attempt
                        // switches on and lets the comparator trip again if needed
                        if (!sense.overtemp[i] && !undervoltage_sense)
                            next_cur.latched_off[i] = 1'b0;             // [RULE11]
                        next_cur.inrush[i] = 1'b1;                      // [RULE13]
                        next_cur.retries[i] = cur.retries[i] + 5'h01;
                        next_cur.rstate[i]  = (cur.retries[i] + 5'h01 >= `SWS_RETRY_MAX)
                                              ? RS_EXHAUSTED : RS_IDLE; // [RULE11] [RULE24]
                    end else begin
                        next_cur.timer[i] = cur.timer[i] + 32'd1;
                    end
                end
                RS_EXHAUSTED: next_cur.rstate[i] = RS_EXHAUSTED;        // [RULE24]
                default:      next_cur.rstate[i] = RS_IDLE;
            endcase
            if (output_command[i] && !cur.cmd_prev[i])
                next_cur.inrush[i] = 1'b1;
            if (retry_reset) begin                                      // [RULE12]
                next_cur.retries[i] = '0;
                next_cur.rstate[i]  = RS_IDLE;
            end

            // Off-state diagnostics, latched only once the gate is down
            off_now[i] = !cur.on_out[i];
            if (off_now[i] && sense.short_sense[i] && !cfg.short_to_supply_disable[i]) begin
                next_cur.st.short_to_supply_flag[i] = 1'b1;             // [RULE14] [RULE15]
                next_cur.st.off_open_load_flag[i]   = 1'b1;
            end
            if (off_now[i] && sense.off_open_sense[i] && !cfg.off_open_load_disable[i])
                next_cur.st.off_open_load_flag[i] = 1'b1;               // [RULE16] [RULE17]

            // On-state open load; LED mode only at full duty after a period
            next_cur.on_time[i] = cur.on_out[i]
                ? ((cur.on_time[i] >= LED_OPEN_LOAD_SELECT_CYC - 1) ? '0 : cur.on_time[i] + 32'd1) : '0;
            if (cur.on_out[i] && sense.on_low_current[i] && !cfg.on_open_load_disable[i]) begin
                if (!cfg.led_open_load_select[i])
                    next_cur.st.on_open_load_flag[i] = 1'b1;            // [RULE18]
                else if (duty[i] == `SWS_DUTY_FULL && cur.on_time[i] >= LED_OPEN_LOAD_SELECT_CYC - 1)
                    next_cur.st.on_open_load_flag[i] = 1'b1;            // [RULE19]
            end
        end

        next_cur.on_out = output_command & ~next_cur.latched_off
                          & {N{~next_cur.ov_off}} & {N{~undervoltage_sense}};  // [RULE1] [RULE5]

        // Supply failure wipes supply, overtemp and overcurrent flags and all latch-offs
        if (latch_clear) begin                                          // [RULE9]
            next_cur.st.overtemp_flag     = '0;
            next_cur.st.overcurrent_flag  = '0;
            next_cur.st.overvoltage_flag  = 1'b0;
            next_cur.st.undervoltage_flag = 1'b0;
            next_cur.latched_off          = '0;
            next_cur.ov_off               = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (rst)
            cur <= '0;
        else if (clk_en)
            cur <= next_cur;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign switch_output  = cur.on_out;
    assign inrush_restore = cur.inrush;                                 // [RULE13]
    assign status         = cur.st;
    // Sense only while the switch conducts, and never in fail-safe
    assign sense_output   = (cfg.sense_route != 2'h0 && !fail_safe_mode)
                            ? cur.on_out : 4'h0;                        // [RULE21]
    // Pin is low on over-voltage shutdown, under-voltage, overtemp, off-state short or open load and latched-off commanded outputs
    assign fault_flag_pin = !(cur.ov_off || undervoltage_sense
                              || |(cur.latched_off & output_command)
                              || |(sense.overtemp)
                              || |(sense.short_sense & ~cfg.short_to_supply_disable & ~cur.on_out)
                              || |(sense.off_open_sense & ~cfg.off_open_load_disable
                                   & ~cur.on_out));                     // [RULE6] [RULE14]
endmodule

// ===== sws_mcu_model.sv
// Microcontroller side of the link: turns bench requests into read strobes.
// Assumes one-cycle requests launched just after a rising edge.
`timescale 1ns/1ps
// ==========================================
// Read strobe generator
module sws_mcu_model #(
    parameter int LAG = 1
) (
    // Clock and request
    input  wire logic sys_clk,
    input  wire logic rd_req,
    // Strobe to the device
    output logic      status_read
);
    logic [7:0] pipe;
    initial pipe = 8'h00;
    // A larger LAG stands for a slow transfer before the strobe
    always @(posedge sys_clk) pipe <= {pipe[6:0], rd_req};
    assign status_read = pipe[LAG-1];
endmodule

// ===== switch_fault_supervisor_props.sv
// Port-level checks for the switch fault supervisor.
// Assumes binding onto the top module; sees only its ports.
`timescale 1ns/1ps
// ==========================================
// Checker
module sws_props (
    // Clock and inputs
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 clk_en,
    input wire logic                 overvoltage_sense,
    input wire logic                 undervoltage_sense,
    input wire logic                 logic_supply_fail,
    input wire logic                 supply_por,
    input wire logic                 fail_safe_mode,
    input wire logic                 wake_reset_in,
    input wire logic                 prewarn_sense,
    input wire logic                 status_read,
    input wire sws_pkg::config_s     cfg,
    // Results
    input wire logic [3:0]           switch_output,
    input wire logic [3:0]           sense_output,
    input wire logic                 fault_flag_pin,
    input wire sws_pkg::status_s     status
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ov_shutdown: assert property (overvoltage_sense && clk_en &&
        !cfg.overvoltage_protect_disable && (!fail_safe_mode || wake_reset_in)
        |=> switch_output == 4'h0) else $error("outputs on during over-voltage");
    a_ov_flag: assert property (overvoltage_sense && clk_en && !fail_safe_mode
        |=> status.overvoltage_flag) else $error("over-voltage flag not set");
    a_uv_off: assert property (undervoltage_sense && clk_en
        |=> switch_output == 4'h0 && status.undervoltage_flag) else $error("under-voltage missed");
    a_uv_pin: assert property (undervoltage_sense [*2] |-> !fault_flag_pin)
        else $error("fault pin high in under-voltage");
    a_sense_gate: assert property ((sense_output & ~switch_output) == 4'h0)
        else $error("sense active on an off output");
    a_sense_fs: assert property (fail_safe_mode |-> sense_output == 4'h0)
        else $error("sense active in fail-safe");
    a_uv_sticky: assert property (status.undervoltage_flag && !status_read &&
        !supply_por && !logic_supply_fail && $stable(fail_safe_mode)
        |=> status.undervoltage_flag) else $error("under-voltage flag lost");
    a_por_clear: assert property (supply_por && clk_en && !undervoltage_sense
        && !overvoltage_sense |=> !status.undervoltage_flag && !status.overvoltage_flag)
        else $error("supply flags survive power-on reset");
    a_prewarn_set: assert property (prewarn_sense && clk_en && !fail_safe_mode
        |=> status.temp_prewarn_flag) else $error("prewarning not latched");
    a_short_masked: assert property (cfg.short_to_supply_disable[2] && clk_en &&
        !status.short_to_supply_flag[2] |=> !status.short_to_supply_flag[2])
        else $error("short flag set while disabled");
endmodule

bind switch_fault_supervisor sws_props u_props (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .overvoltage_sense(overvoltage_sense),
    .undervoltage_sense(undervoltage_sense), .logic_supply_fail(logic_supply_fail),
    .supply_por(supply_por), .fail_safe_mode(fail_safe_mode), .wake_reset_in(wake_reset_in),
    .prewarn_sense(prewarn_sense), .status_read(status_read), .cfg(cfg),
    .switch_output(switch_output), .sense_output(sense_output),
    .fault_flag_pin(fault_flag_pin), .status(status)
);

// ===== test_switch_fault_supervisor.sv
// Self-checking bench for the switch fault supervisor.
// Assumes shortened retry and LED periods; status reads come from the model.
`timescale 1ns/1ps
// ==========================================
// Bench
module test_switch_fault_supervisor;
    import sws_pkg::*;
    typedef struct packed {logic [3:0] c; logic o, u, d, f, w; logic [3:0] s; logic ovf, uvf;} row_s;
    logic sys_clk, rst, ov, ovc, uv, lsf, por, fs, wk, fm, pw, rd_req, status_read, pin, p;
    logic [3:0] cmd, sw, inr, sns;
    chan_sense_s sn;
    config_s     cfg;
    status_s     st;
    int          errors, checks, cyc, n, m;
    row_s rows[6] = '{{4'hf, 5'b00001, 4'hf, 2'b00}, {4'hf, 5'b10001, 4'h0, 2'b10},
                      {4'hf, 5'b10101, 4'hf, 2'b10}, {4'hf, 5'b01001, 4'h0, 2'b01},
                      {4'h3, 5'b10010, 4'h3, 2'b00}, {4'h3, 5'b10011, 4'h0, 2'b00}};
    switch_fault_supervisor #(.AUTO_PERIOD_CYC(20), .LED_OPEN_LOAD_SELECT_CYC(10)) dut (
        .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .overvoltage_sense(ov),
        .overvoltage_clear_sense(ovc), .undervoltage_sense(uv), .logic_supply_fail(lsf),
        .supply_por(por), .fail_safe_mode(fs), .wake_reset_in(wk), .fault_mode(fm),
        .prewarn_sense(pw), .output_command(cmd), .duty({4{7'h7f}}), .sense(sn), .cfg(cfg),
        .status_read(status_read), .switch_output(sw), .inrush_restore(inr),
        .sense_output(sns), .fault_flag_pin(pin), .status(st));
    sws_mcu_model mcu (.sys_clk(sys_clk), .rd_req(rd_req), .status_read(status_read));
    initial begin
        sys_clk = 0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic reset();
        {ov, uv, lsf, por, fs, fm, pw, rd_req, cmd, sn, cfg} = '0;
        {rst, ovc, wk} = 3'b111;
        step(2);
        rst = 0;
    endtask
    task automatic rd();
        rd_req = 1;
        step(1);
        rd_req = 0;
        step(2);
    endtask
    initial begin
        rst = 1;
        step(14);
        reset();
        step(15);
        chk({st, pin}, 1);
        foreach (rows[i]) begin
            reset();
            {cmd, ov, uv, cfg.overvoltage_protect_disable, fs, wk} = rows[i][14:6];
            ovc = !ov;
            step(2);
            chk(sw, rows[i].s);
            if (!rows[i].f) chk({st.overvoltage_flag, st.undervoltage_flag}, rows[i][1:0]);
            $display("row %0d done", i);
        end
        // Hysteresis band keeps outputs off; warning clears only once gone
        reset(); cmd = 4'hf; step(2); ov = 1; ovc = 0; step(2); ov = 0; step(3);
        chk(sw, 0);
        ovc = 1; step(2); chk(sw, 4'hf);
        rd(); chk(st.overvoltage_flag, 0);
        cfg.overvoltage_protect_disable = 1; ov = 1; step(2); rd();
        chk({sw, st.overvoltage_flag}, 5'h1f);
        ov = 0; rd(); chk(st.overvoltage_flag, 0);
        $display("over-voltage test done");
        reset(); uv = 1; step(2); uv = 0; step(2);
        chk({pin, st.undervoltage_flag}, 2'b11);
        reset(); fm = 1; cmd = 4'h1; step(2); uv = 1; step(3); uv = 0; step(2);
        chk({sw, pin}, 0);
        n = 5;
        while (sw[0] !== 1'b1 && n < 60) begin step(1); n++; end
        chk(n >= 19 && n <= 24, 1);
        chk(st.undervoltage_flag, 1);
        rd(); chk(st.undervoltage_flag, 0);
        $display("under-voltage test done");
        // Overcurrent held: every retry trips again until the count runs out
        reset(); fm = 1; cmd = 4'h2; step(3); sn.overcurrent = 4'h2; n = 0; m = 0; p = 1;
        repeat (600) begin step(1); n += (sw[1] && !p); m += inr[1]; p = sw[1]; end
        chk(n, 16);
        chk(m, 16);
        sn.overcurrent = 0; step(30); chk({sw[1], pin}, 0);
        cmd = 0; step(2); cmd = 4'h2; step(3); chk(sw[1], 1);
        $display("retry test done");
        reset(); sn.short_sense = 4'h4; sn.off_open_sense = 4'h8;
        cfg.short_to_supply_disable = 4'h4; cfg.off_open_load_disable = 4'h8; step(3);
        chk({st.short_to_supply_flag, st.off_open_load_flag}, 0);
        cfg = '0; step(3);
        chk({st.short_to_supply_flag, st.off_open_load_flag, pin}, 9'h098);
        sn = '0; step(1); chk(pin, 1);
        rd(); chk({st.short_to_supply_flag, st.off_open_load_flag}, 0);
        reset(); cmd = 4'h8; step(2); sn.on_low_current = 4'h8; step(3);
        chk({sw, pin, st.on_open_load_flag}, 9'h118);
        sn = '0; rd(); chk(st.on_open_load_flag, 0);
        pw = 1; step(2); pw = 0; chk(st.temp_prewarn_flag, 1);
        uv = 1; step(2); uv = 0; por = 1; step(2); por = 0;
        chk({st.undervoltage_flag, st.overvoltage_flag}, 0);
        cfg.sense_route = 2'h1; cmd = 4'h5; step(2);
        chk(sns, 4'h5);
        fs = 1; step(1); chk(sns, 0);
        $display("diagnostic test done");
        finish_test();
    end
endmodule
